// file: design/rscc_core.sv
// Ring slave cycle control: state machine, timing pulses, banked memories
//
// Function
// - Initial state discards frames; I/O slave leaves it for setup A alone.
// - Firmware writes init-done 1; device then enters setup A.
// - Setup A: setup-A frame answered with node info, then setup B.
// - Setup B: answer setup-B with info; setup-A returns; others ignored.
// - Setup B enters running on first real-time frame, no firmware.
// - Own block position in receive memory frozen after setup B.
// - Running: real-time exchange; setup-A drops to setup A; others ignored.
// - Soft reset write of 1 forces the initial state.
// - Receive-event and sync are active-low pulses 1.28 us long.
// - Every completely received frame without a no-reply error gives a receive-event pulse.
// - Running timeout also pulses receive-event unless masked.
// - Sync pulses only in running, after a complete real-time frame.
// - I/O slave samples inputs and updates outputs at sync.
// - Each answered frame starts one transmission of previously committed data.
// - Unanswerable errored frame: bytes still stored, but no bank swap and no timing pulses.
// - Transmit and receive memories have two banks, CPU and engine.
// - Transmit swap write self-clears; deferred while transmitting.
// - Receive banks swap on each answered frame; deferred while hold is 1.
// - Slave data stored in cable order; position status locates own block.
// - Memory words little-endian: byte 4n+0 holds bits 7 to 0.
`timescale 1ns/100ps
module rscc_core
   import rscc_pkg::*;
(
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                reset_n,
   // Register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [DATA_W-1:0]   reg_rdata,
   // Link engine side
   input  wire rscc_rx_s            eng_rx,
   input  wire logic                eng_rx_timeout_tick,
   input  wire rscc_bytewr_s        eng_rx_wr,
   input  wire logic [EADDR_W-1:0]  eng_tx_addr,
   input  wire logic                eng_tx_busy,
   output logic      [7:0]          eng_tx_byte,
   output rscc_txcmd_s              eng_tx_cmd,
   // Pins
   input  wire logic                io_mode,
   input  wire logic [DATA_W-1:0]   io_in,
   output logic      [DATA_W-1:0]   io_out,
   output logic                     rx_event_pulse_n,
   output logic                     sync_pulse_n
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic              mode_s1_r, mode_s2_r, mode_s3_r, io_mode_r;
   logic [DATA_W-1:0] in_s1_r, in_s2_r, in_s3_r, io_in_r;
   wire  [DATA_W-1:0] in_agree = ~(in_s2_r ^ in_s3_r);

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge mclk) begin
      mode_s1_r <= io_mode;
      mode_s2_r <= mode_s1_r;
      mode_s3_r <= mode_s2_r;
      in_s1_r   <= io_in;
      in_s2_r   <= in_s1_r;
      in_s3_r   <= in_s2_r;
      if (!reset_n) begin
         io_mode_r <= 1'b0;
         io_in_r   <= '0;
      end else begin
         if (mode_s2_r == mode_s3_r)
            io_mode_r <= mode_s3_r;
         io_in_r <= (in_s3_r & in_agree) | (io_in_r & ~in_agree);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register decode

   logic soft_rst_r;
   wire  rst_all = !reset_n || soft_rst_r;

   wire wr_ctl   = reg_wr && reg_wdata[CTRL_BIT];
   wire wr_rst   = wr_ctl && (reg_addr == OFS_SOFT_RST);
   wire wr_tmo   = reg_wr && (reg_addr == OFS_TIMEOUT);
   wire wr_init  = reg_wr && (reg_addr == OFS_INIT_DONE);
   wire wr_tmask = reg_wr && (reg_addr == OFS_TMO_MASK);
   wire wr_sdly  = reg_wr && (reg_addr == OFS_SYNC_DELAY);
   wire wr_smask = reg_wr && (reg_addr == OFS_SYNC_MASK);
   wire wr_swap  = wr_ctl && (reg_addr == OFS_TX_SWAP);
   wire wr_hold  = reg_wr && (reg_addr == OFS_RX_HOLD);
   wire txm_hit  = (reg_addr[ADDR_W-1:MW_IDX+2] ==
                    OFS_TXMEM_BASE[ADDR_W-1:MW_IDX+2]);
   wire rxm_hit  = (reg_addr[ADDR_W-1:MW_IDX+2] ==
                    OFS_RXMEM_BASE[ADDR_W-1:MW_IDX+2]);
   wire [MW_IDX-1:0] cpu_idx = reg_addr[MW_IDX+1:2];
   wire wr_txm   = reg_wr && txm_hit;

   // Soft reset pulse clears all control state on the next edge
   always_ff @(posedge mclk) begin
      if (!reset_n)
         soft_rst_r <= 1'b0;
      else
         soft_rst_r <= wr_rst;
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   logic [TIMEOUT_W-1:0] timeout_r;
   logic [SDLY_W-1:0]    sdly_r;
   logic                 init_done_r, tmo_mask_r, sync_mask_r, rx_hold_r;

   always_ff @(posedge mclk) begin
      if (rst_all) begin
         timeout_r   <= TIMEOUT_RST;
         sdly_r      <= SDLY_RST;
         init_done_r <= 1'b0;
         tmo_mask_r  <= 1'b0;
         sync_mask_r <= 1'b0;
         rx_hold_r   <= 1'b0;
      end else begin
         if (wr_tmo)   timeout_r   <= reg_wdata[TIMEOUT_W-1:0];
         if (wr_sdly)  sdly_r      <= reg_wdata[SDLY_W-1:0];
         if (wr_init)  init_done_r <= reg_wdata[CTRL_BIT];
         if (wr_tmask) tmo_mask_r  <= reg_wdata[CTRL_BIT];
         if (wr_smask) sync_mask_r <= reg_wdata[CTRL_BIT];
         if (wr_hold)  rx_hold_r   <= reg_wdata[CTRL_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slave state machine

   rscc_state_e state_r, state_nxt;
   logic        reply, add_info, pos_latch, sync_trig;
   wire         fr_ok = eng_rx.done && !eng_rx.noreply_err;

   // Next state, reply decision and block position capture
   always_comb begin
      state_nxt = state_r;
      reply     = 1'b0;
      add_info  = 1'b0;
      pos_latch = 1'b0;
      sync_trig = 1'b0;
      case (state_r)
         ST_INITIAL: begin
            // Frames are discarded here
            if (init_done_r || io_mode_r)
               state_nxt = ST_CONFIG_A;
         end
         ST_CONFIG_A: begin
            if (fr_ok && eng_rx.ftype == FT_SETUP_A) begin
               reply     = 1'b1;
               add_info  = 1'b1;
               state_nxt = ST_CONFIG_B;
            end
         end
         ST_CONFIG_B: begin
            if (fr_ok) begin
               case (eng_rx.ftype)
                  FT_SETUP_B: begin
                     reply     = 1'b1;
                     add_info  = 1'b1;
                     pos_latch = 1'b1;
                  end
                  FT_SETUP_A: begin
                     reply     = 1'b1;
                     add_info  = 1'b1;
                     state_nxt = ST_CONFIG_A;
                  end
                  FT_REALTIME: begin
                     reply     = 1'b1;
                     sync_trig = 1'b1;
                     state_nxt = ST_RUNNING;
                  end
                  default: ;
               endcase
            end
         end
         ST_RUNNING: begin
            if (fr_ok && eng_rx.ftype == FT_REALTIME) begin
               reply     = 1'b1;
               sync_trig = 1'b1;
            end else if (fr_ok && eng_rx.ftype == FT_SETUP_A) begin
               reply     = 1'b1;
               add_info  = 1'b1;
               state_nxt = ST_CONFIG_A;
            end
         end
         default: state_nxt = ST_INITIAL;
      endcase
   end

   logic [POS_W-1:0] blk_pos_r;

   // State, frozen block position and one transmit per accepted frame
   always_ff @(posedge mclk) begin
      if (rst_all) begin
         state_r    <= ST_INITIAL;
         blk_pos_r  <= '0;
         eng_tx_cmd <= '0;
      end else begin
         state_r <= state_nxt;
         if (pos_latch)
            blk_pos_r <= eng_rx.blk_pos;
         eng_tx_cmd.start         <= reply;
         eng_tx_cmd.add_node_info <= add_info;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bank control

   logic tx_eng_bank_r, tx_swap_pend_r, rx_eng_bank_r, rx_swap_pend_r;
   wire  tx_do_swap = tx_swap_pend_r && !eng_tx_busy && !eng_tx_cmd.start;
   wire  rx_want    = reply || rx_swap_pend_r;
   wire  rx_do_swap = rx_want && !rx_hold_r;

   // Swaps alternate the CPU and engine banks; a new request beats the clear
   always_ff @(posedge mclk) begin
      if (rst_all) begin
         tx_eng_bank_r  <= 1'b0;
         tx_swap_pend_r <= 1'b0;
         rx_eng_bank_r  <= 1'b0;
         rx_swap_pend_r <= 1'b0;
      end else begin
         tx_swap_pend_r <= wr_swap || (tx_swap_pend_r && !tx_do_swap);
         if (tx_do_swap)
            tx_eng_bank_r <= !tx_eng_bank_r;
         rx_swap_pend_r <= rx_want && rx_hold_r;
         if (rx_do_swap)
            rx_eng_bank_r <= !rx_eng_bank_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Banked memories

   logic [DATA_W-1:0] tx_mem [2*MEM_WORDS];
   logic [DATA_W-1:0] rx_mem [2*MEM_WORDS];
   wire  [MW_IDX-1:0] eng_idx  = eng_rx_wr.addr[EADDR_W-1:2];
   wire  [1:0]        eng_lane = eng_rx_wr.addr[1:0];
   wire               rx_store = eng_rx_wr.we && (state_r != ST_INITIAL);

   // Per entry: CPU writes its transmit bank, engine stores bytes
   for (genvar gi = 0; gi < 2*MEM_WORDS; gi++) begin : g_mem
      localparam logic             G_BANK = 1'(gi / MEM_WORDS);
      localparam logic [MW_IDX-1:0] G_IDX = MW_IDX'(gi % MEM_WORDS);
      wire tx_sel = wr_txm && (cpu_idx == G_IDX)
                    && (G_BANK != tx_eng_bank_r);
      wire rx_sel = rx_store && (eng_idx == G_IDX)
                    && (G_BANK == rx_eng_bank_r);
      always_ff @(posedge mclk) begin
         if (rst_all) begin
            tx_mem[gi] <= '0;
            rx_mem[gi] <= '0;
         end else begin
            if (tx_sel)
               tx_mem[gi] <= reg_wdata;
            if (rx_sel)
               rx_mem[gi][eng_lane*8 +: 8] <= eng_rx_wr.data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Engine transmit byte fetch

   logic [DATA_W-1:0] io_cap_r;
   wire  [DATA_W-1:0] tx_word = io_mode_r ? io_cap_r :
                        tx_mem[{tx_eng_bank_r, eng_tx_addr[EADDR_W-1:2]}];
   wire  [7:0]        tx_byte = tx_word[eng_tx_addr[1:0]*8 +: 8];

   // Byte appears one cycle after its address
   always_ff @(posedge mclk) begin
      if (rst_all)
         eng_tx_byte <= '0;
      else
         eng_tx_byte <= tx_byte;
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive timeout in running state

   logic [CNT_W-1:0]     tmo_unit_r;
   logic [TIMEOUT_W-1:0] tmo_cnt_r;
   wire  unit_end = (tmo_unit_r == CNT_W'(TMO_UNIT_CYC - 1));
   wire  tmo_hit  = unit_end && (tmo_cnt_r == timeout_r - 8'h01);
   wire  tmo_run  = (state_r == ST_RUNNING) && (timeout_r != '0)
                    && !eng_rx.done;

   // Counts whole detection units since the last completed frame
   always_ff @(posedge mclk) begin
      if (rst_all || !tmo_run || tmo_hit) begin
         tmo_unit_r <= '0;
         tmo_cnt_r  <= '0;
      end else if (unit_end) begin
         tmo_unit_r <= '0;
         tmo_cnt_r  <= tmo_cnt_r + 8'h01;
      end else begin
         tmo_unit_r <= tmo_unit_r + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive-event pulse

   logic [CNT_W-1:0] rxp_cnt_r;
   wire  rx_fire = fr_ok || (tmo_hit && tmo_run && !tmo_mask_r);
   wire  [CNT_W-1:0] rxp_nxt = rx_fire ? CNT_W'(PULSE_CYC) :
                       (rxp_cnt_r != '0) ? rxp_cnt_r - 12'h001 : '0;

   // Low for the pulse length after each event
   always_ff @(posedge mclk) begin
      if (rst_all) begin
         rxp_cnt_r        <= '0;
         rx_event_pulse_n <= 1'b1;
      end else begin
         rxp_cnt_r        <= rxp_nxt;
         rx_event_pulse_n <= (rxp_nxt == '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sync delay and pulse

   logic [CNT_W-1:0] sdly_cnt_r, syp_cnt_r;
   logic             sdly_busy_r;
   wire  [CNT_W-1:0] sdly_load = CNT_W'(sdly_r * SDLY_UNIT_CYC);
   wire  sync_now  = (sync_trig && sdly_r == '0) ||
                     (sdly_busy_r && sdly_cnt_r == 12'h001);
   wire  sync_fire = sync_now && (state_r == ST_RUNNING
                                  || state_nxt == ST_RUNNING);
   wire  [CNT_W-1:0] syp_nxt = (sync_fire && !sync_mask_r) ?
                       CNT_W'(PULSE_CYC) :
                       (syp_cnt_r != '0) ? syp_cnt_r - 12'h001 : '0;

   // Optional local delay, then the low pulse
   always_ff @(posedge mclk) begin
      if (rst_all) begin
         sdly_busy_r  <= 1'b0;
         sdly_cnt_r   <= '0;
         syp_cnt_r    <= '0;
         sync_pulse_n <= 1'b1;
      end else begin
         if (sync_trig && sdly_r != '0) begin
            sdly_busy_r <= 1'b1;
            sdly_cnt_r  <= sdly_load;
         end else if (sdly_busy_r) begin
            sdly_busy_r <= (sdly_cnt_r != 12'h001);
            sdly_cnt_r  <= sdly_cnt_r - 12'h001;
         end
         syp_cnt_r    <= syp_nxt;
         sync_pulse_n <= (syp_nxt == '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // I/O slave pin exchange at sync

   wire [DATA_W-1:0] own_rx_word =
        rx_mem[{rx_eng_bank_r ^ !rx_do_swap, blk_pos_r[MW_IDX-1:0]}];

   // Sample inputs and refresh outputs on the sync moment
   always_ff @(posedge mclk) begin
      if (rst_all) begin
         io_cap_r <= '0;
         io_out   <= '0;
      end else if (sync_fire && io_mode_r) begin
         io_cap_r <= io_in_r;
         io_out   <= own_rx_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read

   wire [DATA_W-1:0] rd_txm = tx_mem[{!tx_eng_bank_r, cpu_idx}];
   wire [DATA_W-1:0] rd_rxm = rx_mem[{!rx_eng_bank_r, cpu_idx}];
   logic [DATA_W-1:0] rd_mux;

   // Unmapped addresses and write-only registers read as zero
   always_comb begin
      rd_mux = '0;
      case (reg_addr)
         OFS_TIMEOUT:    rd_mux[TIMEOUT_W-1:0] = timeout_r;
         OFS_INIT_DONE:  rd_mux[CTRL_BIT]      = init_done_r;
         OFS_TMO_MASK:   rd_mux[CTRL_BIT]      = tmo_mask_r;
         OFS_SYNC_DELAY: rd_mux[SDLY_W-1:0]    = sdly_r;
         OFS_SYNC_MASK:  rd_mux[CTRL_BIT]      = sync_mask_r;
         OFS_TX_SWAP:    rd_mux[CTRL_BIT]      = tx_swap_pend_r;
         OFS_RX_HOLD:    rd_mux[CTRL_BIT]      = rx_hold_r;
         OFS_STATE:      rd_mux[1:0]           = state_r;
         OFS_BLK_POS:    rd_mux[POS_W-1:0]     = blk_pos_r;
         OFS_IO_IN:      rd_mux                = io_cap_r;
         default: begin
            if (txm_hit)
               rd_mux = rd_txm;
            else if (rxm_hit)
               rd_mux = rd_rxm;
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!reset_n)
         reg_rdata <= '0;
      else
         reg_rdata <= reg_rd ? rd_mux : '0;
   end

endmodule : rscc_core

// file: design/rscc_pkg.sv
// Shared constants and carrier types for the ring slave cycle control block
package rscc_pkg;

   // Clock rate and timing figures in their own units
   localparam int unsigned CLK_MHZ       = 40;
   localparam int unsigned PULSE_NS      = 1280;
   localparam int unsigned TMO_UNIT_NS   = 81920;
   localparam int unsigned SDLY_UNIT_NS  = 640;

   // Cycle counts derived from the rate, rounded up
   localparam int unsigned PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned TMO_UNIT_CYC  = (TMO_UNIT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SDLY_UNIT_CYC = (SDLY_UNIT_NS * CLK_MHZ + 999) / 1000;

   // Widths
   localparam int unsigned ADDR_W    = 12;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned MEM_WORDS = 8;
   localparam int unsigned MW_IDX    = 3;
   localparam int unsigned EADDR_W   = 5;
   localparam int unsigned POS_W     = 5;
   localparam int unsigned CNT_W     = 12;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_SOFT_RST   = 12'h500;
   localparam logic [ADDR_W-1:0] OFS_TIMEOUT    = 12'h50C;
   localparam logic [ADDR_W-1:0] OFS_INIT_DONE  = 12'h510;
   localparam logic [ADDR_W-1:0] OFS_TMO_MASK   = 12'h514;
   localparam logic [ADDR_W-1:0] OFS_SYNC_DELAY = 12'h518;
   localparam logic [ADDR_W-1:0] OFS_SYNC_MASK  = 12'h51C;
   localparam logic [ADDR_W-1:0] OFS_TX_SWAP    = 12'h530;
   localparam logic [ADDR_W-1:0] OFS_RX_HOLD    = 12'h534;
   localparam logic [ADDR_W-1:0] OFS_STATE      = 12'h544;
   localparam logic [ADDR_W-1:0] OFS_BLK_POS    = 12'h55C;
   localparam logic [ADDR_W-1:0] OFS_IO_IN      = 12'h560;
   localparam logic [ADDR_W-1:0] OFS_TXMEM_BASE = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_RXMEM_BASE = 12'h100;

   // Field positions and reset values
   localparam int unsigned      CTRL_BIT      = 0;
   localparam int unsigned      TIMEOUT_W     = 8;
   localparam int unsigned      SDLY_W        = 7;
   localparam logic [7:0]       TIMEOUT_RST   = 8'hFF;
   localparam logic [SDLY_W-1:0] SDLY_RST     = 7'h00;

   // Slave states
   typedef enum logic [1:0] {
      ST_INITIAL  = 2'b00,
      ST_CONFIG_A = 2'b01,
      ST_CONFIG_B = 2'b10,
      ST_RUNNING  = 2'b11
   } rscc_state_e;

   // Received frame kinds
   typedef enum logic [1:0] {
      FT_SETUP_A  = 2'b00,
      FT_SETUP_B  = 2'b01,
      FT_REALTIME = 2'b10,
      FT_OTHER    = 2'b11
   } rscc_ftype_e;

   // Reception completion report from the link engine
   typedef struct packed {
      logic              done;
      logic              noreply_err;
      rscc_ftype_e       ftype;
      logic [POS_W-1:0]  blk_pos;
   } rscc_rx_s;

   // Byte write from the link engine into receive memory
   typedef struct packed {
      logic               we;
      logic [EADDR_W-1:0] addr;
      logic [7:0]         data;
   } rscc_bytewr_s;

   // Transmit command to the link engine
   typedef struct packed {
      logic start;
      logic add_node_info;
   } rscc_txcmd_s;

endpackage : rscc_pkg

// file: verification/rscc_checker.sv
// Port-level assertions for the ring slave cycle control block
`timescale 1ns/100ps
module rscc_checker
   import rscc_pkg::*;
(
   // Clock and reset
   input wire logic              mclk,
   input wire logic              reset_n,
   // Register port
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Link engine side
   input wire rscc_rx_s          eng_rx,
   input wire rscc_txcmd_s       eng_tx_cmd,
   // Pins
   input wire logic              rx_event_pulse_n,
   input wire logic              sync_pulse_n
);
   localparam int SYNC_MAX = 3303;
   logic [6:0]  ev_cnt_r;
   logic [6:0]  sy_cnt_r;
   logic [11:0] rt_age_r;
   //////////////////////////////////////////////////
   // Saturating low-time counters and age of the last real-time frame
   always_ff @(posedge mclk) begin
      ev_cnt_r <= (!reset_n || rx_event_pulse_n) ? 7'h00
                  : ev_cnt_r + 7'(ev_cnt_r != 7'h7F);
      sy_cnt_r <= (!reset_n || sync_pulse_n) ? 7'h00
                  : sy_cnt_r + 7'(sy_cnt_r != 7'h7F);
      rt_age_r <= !reset_n ? 12'hFFF
                  : (eng_rx.done && !eng_rx.noreply_err
                     && eng_rx.ftype == FT_REALTIME) ? 12'h000
                  : rt_age_r + 12'(rt_age_r != 12'hFFF);
   end
   // Assertions
   chk_start_cause: assert property (@(posedge mclk)
      disable iff (!reset_n) eng_tx_cmd.start
      |-> $past(eng_rx.done && !eng_rx.noreply_err))
      else $error("transmit start without a good frame");
   chk_noreply_quiet: assert property (@(posedge mclk)
      disable iff (!reset_n) eng_rx.done && eng_rx.noreply_err
      |=> !eng_tx_cmd.start && !$fell(rx_event_pulse_n)
          && !$fell(sync_pulse_n))
      else $error("unanswerable frame produced activity");
   chk_event_fall: assert property (@(posedge mclk)
      disable iff (!reset_n) eng_rx.done && !eng_rx.noreply_err
      |=> !rx_event_pulse_n)
      else $error("receive event missing after frame");
   chk_event_width: assert property (@(posedge mclk)
      disable iff (!reset_n) $rose(rx_event_pulse_n)
      |-> ev_cnt_r >= PULSE_CYC)
      else $error("receive event pulse too short");
   chk_sync_width: assert property (@(posedge mclk)
      disable iff (!reset_n) $rose(sync_pulse_n) |-> sy_cnt_r >= PULSE_CYC)
      else $error("sync pulse too short");
   chk_sync_after_rt: assert property (@(posedge mclk)
      disable iff (!reset_n) $fell(sync_pulse_n) |-> rt_age_r <= SYNC_MAX)
      else $error("sync pulse without recent real-time frame");
   chk_reset_idle: assert property (@(posedge mclk)
      !reset_n |=> rx_event_pulse_n && sync_pulse_n)
      else $error("timing outputs not idle high after reset");
   chk_rdata_idle: assert property (@(posedge mclk)
      disable iff (!reset_n) !$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside its cycle");
endmodule : rscc_checker

bind rscc_core rscc_checker u_chk (.mclk(mclk), .reset_n(reset_n),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_rx(eng_rx),
   .eng_tx_cmd(eng_tx_cmd), .rx_event_pulse_n(rx_event_pulse_n),
   .sync_pulse_n(sync_pulse_n));

// file: verification/rscc_master_model.sv
// Network master stand-in: frame completions, byte stores, tx busy
`timescale 1ns/100ps
module rscc_master_model
   import rscc_pkg::*;
(
   // Clock
   input  wire logic        mclk,
   // Toward the block
   output rscc_rx_s         eng_rx,
   output rscc_bytewr_s     eng_rx_wr,
   output logic             eng_tx_busy,
   // From the block
   input  wire rscc_txcmd_s eng_tx_cmd
);
   int busy_cnt = 0;
   initial begin
      eng_rx = '0;
      eng_rx_wr = '0;
   end
   //////////////////////////////////////////////////
   // Each transmission keeps the line busy for 20 cycles
   always @(posedge mclk) begin
      if (eng_tx_cmd.start) busy_cnt <= 20;
      else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
   end
   assign eng_tx_busy = (busy_cnt != 0);
   // One completed frame; fields scrambled once released
   task automatic send(input rscc_ftype_e ft, input logic err);
      @(posedge mclk);
      eng_rx <= '{1'b1, err, ft, 5'h03};
      @(posedge mclk);
      eng_rx <= '{1'b0, ~err, rscc_ftype_e'(~ft), 5'h1C};
   endtask : send
   // Store one word, byte lanes in address order
   task automatic store(input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         eng_rx_wr <= '{1'b1, 5'(i), w[8*i +: 8]};
      end
      @(posedge mclk);
      eng_rx_wr <= '{1'b0, 5'h1F, ~w[7:0]};
   endtask : store
endmodule : rscc_master_model

// file: verification/ring_slave_cycle_control_test.sv
// Self-checking bench for the ring slave cycle control block
`timescale 1ns/100ps
module ring_slave_cycle_control_test;
   import rscc_pkg::*;
   logic               mclk = 0;
   logic               reset_n = 0;
   logic               reg_wr = 0;
   logic               reg_rd = 0;
   logic               rd_seen = 0;
   logic               io_mode = 0;
   logic [ADDR_W-1:0]  reg_addr = '0;
   logic [DATA_W-1:0]  reg_wdata = '0;
   logic [DATA_W-1:0]  io_in = '0;
   logic [DATA_W-1:0]  reg_rdata, io_out, w0, w1;
   logic [EADDR_W-1:0] eng_tx_addr = '0;
   logic [7:0]         eng_tx_byte;
   logic               eng_tx_busy, ev_n, sy_n;
   rscc_rx_s           eng_rx;
   rscc_bytewr_s       eng_rx_wr;
   rscc_txcmd_s        eng_tx_cmd;
   logic [DATA_W-1:0]  exp_q[$];
   int                 err_count = 0;
   int                 check_count = 0;
   int                 n;
   //////////////////////////////////////////////////
   initial forever #12.5 mclk = ~mclk;
   rscc_core uut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .eng_rx(eng_rx), .eng_rx_timeout_tick(1'b0),
      .eng_rx_wr(eng_rx_wr), .eng_tx_addr(eng_tx_addr),
      .eng_tx_busy(eng_tx_busy), .eng_tx_byte(eng_tx_byte),
      .eng_tx_cmd(eng_tx_cmd), .io_mode(io_mode), .io_in(io_in),
      .io_out(io_out), .rx_event_pulse_n(ev_n), .sync_pulse_n(sy_n));
   rscc_master_model m (.mclk(mclk), .eng_rx(eng_rx),
      .eng_rx_wr(eng_rx_wr), .eng_tx_busy(eng_tx_busy),
      .eng_tx_cmd(eng_tx_cmd));
   // Comparison, verdict and bus cycles
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic frame(input rscc_ftype_e ft, input logic err,
                        input logic st, input logic inf, input rscc_state_e s);
      m.send(ft, err);
      #1;
      check(eng_tx_cmd.start, st);
      if (st) check(eng_tx_cmd.add_node_info, inf);
      check(ev_n, err);
      rd(OFS_STATE, {30'h0, s});
   endtask : frame
   // Read answers are matched with the oldest note
   always @(posedge mclk) begin
      rd_seen <= reg_rd;
      if (rd_seen && exp_q.size() == 0) err_count++;
      else if (rd_seen) check(reg_rdata, exp_q.pop_front());
   end
   // Main sequence
   initial begin
      void'($urandom(32'hC31C));
      w0 = $urandom;
      w1 = $urandom;
      io_in <= $urandom;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(OFS_STATE, 32'h0);
      rd(OFS_TIMEOUT, 32'hFF);
      rd(12'h7FC, 32'h0);
      frame(FT_SETUP_A, 0, 0, 0, ST_INITIAL);
      $display("test initial state done");
      wr(OFS_INIT_DONE, 32'h1);
      frame(FT_REALTIME, 0, 0, 0, ST_CONFIG_A);
      frame(FT_SETUP_A, 0, 1, 1, ST_CONFIG_B);
      frame(FT_SETUP_B, 0, 1, 1, ST_CONFIG_B);
      frame(FT_OTHER, 0, 0, 0, ST_CONFIG_B);
      frame(FT_SETUP_A, 0, 1, 1, ST_CONFIG_A);
      frame(FT_SETUP_A, 0, 1, 1, ST_CONFIG_B);
      frame(FT_SETUP_B, 0, 1, 1, ST_CONFIG_B);
      rd(OFS_BLK_POS, 32'h3);
      $display("test setup phases done");
      m.store(w0);
      frame(FT_REALTIME, 0, 1, 0, ST_RUNNING);
      check(sy_n, 0);
      rd(OFS_RXMEM_BASE, w0);
      wr(OFS_RX_HOLD, 32'h1);
      m.store(w1);
      frame(FT_REALTIME, 0, 1, 0, ST_RUNNING);
      rd(OFS_RXMEM_BASE, w0);
      wr(OFS_RX_HOLD, 32'h0);
      rd(OFS_RXMEM_BASE, w1);
      frame(FT_SETUP_B, 0, 0, 0, ST_RUNNING);
      frame(FT_OTHER, 0, 0, 0, ST_RUNNING);
      repeat (60) @(posedge mclk);
      m.store(w0);
      frame(FT_REALTIME, 1, 0, 0, ST_RUNNING);
      check(sy_n, 1);
      rd(OFS_RXMEM_BASE, w1);
      $display("test running and receive banks done");
      wr(OFS_TXMEM_BASE, w1);
      wr(OFS_SYNC_MASK, 32'h1);
      frame(FT_REALTIME, 0, 1, 0, ST_RUNNING);
      check(sy_n, 1);
      wr(OFS_TX_SWAP, 32'h1);
      rd(OFS_TX_SWAP, 32'h1);
      repeat (25) @(posedge mclk);
      rd(OFS_TX_SWAP, 32'h0);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         eng_tx_addr <= 5'(i);
         @(posedge mclk);
         #1 check(eng_tx_byte, w1[8*i +: 8]);
      end
      $display("test transmit bank done");
      repeat (60) @(posedge mclk);
      wr(OFS_TIMEOUT, 32'h1);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         while (ev_n !== 1'b0 && n < 3400) begin
            @(posedge mclk);
            n++;
         end
         check(n < 3400, k == 0);
         repeat (60) @(posedge mclk);
         wr(OFS_TMO_MASK, 32'h1);
      end
      wr(OFS_SOFT_RST, 32'h1);
      repeat (3) @(posedge mclk);
      rd(OFS_STATE, 32'h0);
      io_mode <= 1'b1;
      repeat (6) @(posedge mclk);
      frame(FT_SETUP_A, 0, 1, 1, ST_CONFIG_B);
      m.store(w1);
      frame(FT_REALTIME, 0, 1, 0, ST_RUNNING);
      check(io_out, w1);
      rd(OFS_IO_IN, io_in);
      repeat (3) @(posedge mclk);
      $display("test timeout and soft reset done");
      report_and_stop();
   end
endmodule : ring_slave_cycle_control_test
